// File: rtl/ldf_pkg.sv
// What this block does
// (RULE_01) 8-bit boost and backlight duty equals code/256; code zero keeps output off.
// (RULE_02) Duty code all ones gives 255/256, never full duty.
// (RULE_03) Blink register bit 7 switches flashing off (0) or on (1).
// (RULE_04) Blink period codes 0..14 give 1 s plus 0.5 s per step.
// (RULE_05) Blink period code 15 keeps tricolour outputs continuously active.
// (RULE_06) On-time codes 0..7 give 0.1,0.15,0.2,0.25,0.3,0.4,0.5,0.6 s.
// (RULE_07) Red register bits 7:6 set shared sink current: off, 4, 8, 12 mA.
// (RULE_08) Red bit 5 picks green (0) or blue (1) as out-of-phase channel.
// (RULE_09) Each colour has 5-bit duty in low bits, code/31 of the frame.
// (RULE_10) Upper three bits of green and blue registers have no effect.
// (RULE_11) Pulse-driver register bit 7 enables the open-drain pulse output.
// (RULE_12) Pulse frequency codes 000..110 give 15.6k,7.8k,4.5k,-,2k,1.5k,1k Hz.
// (RULE_13) Pulse frequency code 111 gives 500 Hz; field resets to 15.6 kHz.
// (RULE_14) All bits of the seven registers are writable and read back.
// (RULE_15) Every field loads its default at reset; duties zero, 1 s, 0.1 s.
// (RULE_16) 8-bit outputs repeat frames of 256 pulses at 183 or 122 Hz.
// (RULE_17) Tricolour sinks stay inactive unless blink enable is set.
// (RULE_18) Pulse code 011 gives 3000 Hz; duty is (code+1)/16.
// (RULE_19) Finite blink: pattern during on-time at period start, off for the rest.
// (RULE_20) New duty codes take effect only at the next frame boundary.
package ldf_pkg;
   // register offsets
   localparam logic [7:0] LDF_OFF_BOOST = 8'h16;
   localparam logic [7:0] LDF_OFF_BLINK = 8'h17;
   localparam logic [7:0] LDF_OFF_RED = 8'h18;
   localparam logic [7:0] LDF_OFF_GREEN = 8'h19;
   localparam logic [7:0] LDF_OFF_BLUE = 8'h1a;
   localparam logic [7:0] LDF_OFF_AUX = 8'h1d;
   localparam logic [7:0] LDF_OFF_BACKLIGHT = 8'h27;
   // values after reset
   localparam logic [7:0] LDF_RST_DUTY = 8'h00;
   localparam logic [7:0] LDF_RST_BLINK = 8'h00;
   localparam logic [7:0] LDF_RST_RED = 8'h00;
   localparam logic [7:0] LDF_RST_AUX = 8'h00;
   // field positions
   localparam int LDF_BIT_EN = 7;
   localparam int LDF_BIT_PHASE = 5;
   localparam logic [3:0] LDF_PER_CONT = 4'hf;
   // timing
   localparam int unsigned LDF_FRAME_HZ_HI = 183;
   localparam int unsigned LDF_FRAME_HZ_LO = 122;
   localparam int unsigned LDF_FRAME_PULSES = 256;
   localparam logic [4:0] LDF_RGB_SLOTS = 5'd31;
   localparam logic [4:0] LDF_RGB_SHIFT = 5'd15;
   localparam int unsigned LDF_BLINK_TICK_MS = 50;
   localparam logic [7:0] LDF_PER_BASE_TICKS = 8'd20;
   localparam logic [7:0] LDF_PER_STEP_TICKS = 8'd10;
   localparam int unsigned LDF_AUX_HZ [8] = '{15600, 7800, 4500, 3000, 2000, 1500, 1000, 500};

   // on-time in blink ticks of 50 ms
   function automatic logic [7:0] ldf_on_ticks(input logic [2:0] code);
      logic [7:0] t;
      t = 8'd2;
      case (code)
         3'd0: t = 8'd2;
         3'd1: t = 8'd3;
         3'd2: t = 8'd4;
         3'd3: t = 8'd5;
         3'd4: t = 8'd6;
         3'd5: t = 8'd8;
         3'd6: t = 8'd10;
         default: t = 8'd12;
      endcase
      return t;
   endfunction
endpackage

// File: rtl/ldf_led_dimming_flash_control.sv
`timescale 1ns/100ps
`default_nettype none
module ldf_led_dimming_flash_control
#(
   parameter int unsigned CLK_HZ = 250_000_000
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // register port, same clock, read data one cycle after reg_rd
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // frame rate select from the other register
   input wire logic frame_rate_select,
   // dimming outputs
   output logic white_led_boost,
   output logic backlight_dimming_output,
   // tricolour sinks
   output logic red_sink_on,
   output logic green_sink_on,
   output logic blue_sink_on,
   output logic [1:0] tricolour_sink_current,
   // open-drain pulse pin, oe_n low pulls the pin
   output logic aux_pulse_o,
   output logic aux_pulse_oe_n
);
   import ldf_pkg::*;

   localparam logic [31:0] DIV_HI = 32'(CLK_HZ / (LDF_FRAME_HZ_HI * LDF_FRAME_PULSES));
   localparam logic [31:0] DIV_LO = 32'(CLK_HZ / (LDF_FRAME_HZ_LO * LDF_FRAME_PULSES));
   localparam logic [31:0] DIV_BLINK = 32'(CLK_HZ / (1000 / LDF_BLINK_TICK_MS));

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] boost_q, blink_q, red_q, green_q, blue_q, aux_q, backl_q;
   logic [7:0] rdata_d;
   logic hit_boost, hit_blink, hit_red, hit_green, hit_blue, hit_aux, hit_backl;

   assign hit_boost = reg_addr == LDF_OFF_BOOST;
   assign hit_blink = reg_addr == LDF_OFF_BLINK;
   assign hit_red = reg_addr == LDF_OFF_RED;
   assign hit_green = reg_addr == LDF_OFF_GREEN;
   assign hit_blue = reg_addr == LDF_OFF_BLUE;
   assign hit_aux = reg_addr == LDF_OFF_AUX;
   assign hit_backl = reg_addr == LDF_OFF_BACKLIGHT;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         boost_q <= LDF_RST_DUTY; // RULE_15
         blink_q <= LDF_RST_BLINK;
         red_q <= LDF_RST_RED;
         green_q <= LDF_RST_DUTY;
         blue_q <= LDF_RST_DUTY;
         aux_q <= LDF_RST_AUX; // RULE_13
         backl_q <= LDF_RST_DUTY;
      end
      else if (reg_wr)
      begin
         if (hit_boost) boost_q <= reg_wdata; // RULE_14
         if (hit_blink) blink_q <= reg_wdata;
         if (hit_red) red_q <= reg_wdata;
         if (hit_green) green_q <= reg_wdata;
         if (hit_blue) blue_q <= reg_wdata;
         if (hit_aux) aux_q <= reg_wdata;
         if (hit_backl) backl_q <= reg_wdata;
      end
   end

   // unmapped offsets read zero
   always_comb
   begin
      if (hit_boost) rdata_d = boost_q;
      else if (hit_blink) rdata_d = blink_q;
      else if (hit_red) rdata_d = red_q;
      else if (hit_green) rdata_d = green_q;
      else if (hit_blue) rdata_d = blue_q;
      else if (hit_aux) rdata_d = aux_q;
      else if (hit_backl) rdata_d = backl_q;
      else rdata_d = 8'h00;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst) reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rdata_d; // RULE_14
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse tick and 256-pulse frame
   logic [31:0] pdiv_q;
   logic [7:0] pidx_q;
   logic ptick, frame_end;
   logic [31:0] pdiv_max;

   assign pdiv_max = (frame_rate_select ? DIV_HI : DIV_LO) - 32'd1; // RULE_16
   assign ptick = pdiv_q >= pdiv_max;
   assign frame_end = ptick && (pidx_q == 8'hff);

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pdiv_q <= 32'd0;
         pidx_q <= 8'h00;
      end
      else
      begin
         pdiv_q <= ptick ? 32'd0 : pdiv_q + 32'd1;
         if (ptick) pidx_q <= pidx_q + 8'd1; // RULE_16
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // 8-bit dimming: spread code full pulses over each frame
   // accumulator spreads on-pulses evenly, so flicker stays at pulse rate
   logic [7:0] boost_code_q, backl_code_q, boost_acc_q, backl_acc_q;
   logic [8:0] boost_sum, backl_sum;

   assign boost_sum = {1'b0, boost_acc_q} + {1'b0, boost_code_q};
   assign backl_sum = {1'b0, backl_acc_q} + {1'b0, backl_code_q};

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         boost_code_q <= 8'h00;
         backl_code_q <= 8'h00;
         boost_acc_q <= 8'h00;
         backl_acc_q <= 8'h00;
         white_led_boost <= 1'b0;
         backlight_dimming_output <= 1'b0;
      end
      else if (ptick)
      begin
         boost_acc_q <= frame_end ? 8'h00 : boost_sum[7:0];
         backl_acc_q <= frame_end ? 8'h00 : backl_sum[7:0];
         white_led_boost <= boost_sum[8]; // RULE_01 RULE_02
         backlight_dimming_output <= backl_sum[8]; // RULE_01 RULE_02
         if (frame_end)
         begin
            boost_code_q <= boost_q; // RULE_20
            backl_code_q <= backl_q; // RULE_20
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tricolour: 31-slot duty frame, blink window
   logic [4:0] slot_q, slot_sh, r_code_q, g_code_q, b_code_q;
   logic slot_end;
   logic [31:0] bdiv_q;
   logic btick;
   logic [7:0] bcnt_q, per_ticks, on_ticks;
   logic blink_en, cont, window, active;
   logic r_on, g_on, b_on;

   assign slot_end = ptick && (slot_q == LDF_RGB_SLOTS - 5'd1);
   assign slot_sh = (slot_q > LDF_RGB_SHIFT) ? slot_q - (LDF_RGB_SHIFT + 5'd1)
                                             : slot_q + LDF_RGB_SHIFT;
   assign blink_en = blink_q[LDF_BIT_EN]; // RULE_03
   assign cont = blink_q[3:0] == LDF_PER_CONT; // RULE_05
   assign per_ticks = LDF_PER_BASE_TICKS + LDF_PER_STEP_TICKS * {4'h0, blink_q[3:0]}; // RULE_04
   assign on_ticks = ldf_on_ticks(blink_q[6:4]); // RULE_06
   assign btick = bdiv_q >= DIV_BLINK - 32'd1;
   assign window = cont || (bcnt_q < on_ticks); // RULE_19
   assign active = blink_en && window && (red_q[7:6] != 2'b00); // RULE_17 RULE_07
   // phase bit picks which channel counts shifted slots
   assign r_on = slot_q < r_code_q;
   assign g_on = (red_q[LDF_BIT_PHASE] ? slot_q : slot_sh) < g_code_q; // RULE_08
   assign b_on = (red_q[LDF_BIT_PHASE] ? slot_sh : slot_q) < b_code_q; // RULE_08

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         slot_q <= 5'd0;
         r_code_q <= 5'd0;
         g_code_q <= 5'd0;
         b_code_q <= 5'd0;
      end
      else if (ptick)
      begin
         slot_q <= slot_end ? 5'd0 : slot_q + 5'd1;
         if (slot_end)
         begin
            r_code_q <= red_q[4:0]; // RULE_09 RULE_20
            g_code_q <= green_q[4:0]; // RULE_10
            b_code_q <= blue_q[4:0]; // RULE_10
         end
      end
   end

   // disabled blink holds the period at its start, so enable opens with on-time
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bdiv_q <= 32'd0;
         bcnt_q <= 8'd0;
      end
      else if (!blink_en)
      begin
         bdiv_q <= 32'd0;
         bcnt_q <= 8'd0;
      end
      else
      begin
         bdiv_q <= btick ? 32'd0 : bdiv_q + 32'd1;
         if (btick) bcnt_q <= (bcnt_q >= per_ticks - 8'd1) ? 8'd0 : bcnt_q + 8'd1; // RULE_04
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         red_sink_on <= 1'b0;
         green_sink_on <= 1'b0;
         blue_sink_on <= 1'b0;
         tricolour_sink_current <= 2'b00;
      end
      else
      begin
         red_sink_on <= active && r_on; // RULE_19
         green_sink_on <= active && g_on;
         blue_sink_on <= active && b_on;
         tricolour_sink_current <= blink_en ? red_q[7:6] : 2'b00; // RULE_07
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // low-frequency open-drain pulse driver
   logic [31:0] aux_div [8];
   logic [31:0] aux_cnt_q, aux_per_q, aux_thr;
   logic [3:0] aux_duty_q;
   logic aux_end, aux_on;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_aux_div
         assign aux_div[gi] = 32'(CLK_HZ / LDF_AUX_HZ[gi]); // RULE_12 RULE_13 RULE_18
      end
   endgenerate

   assign aux_end = aux_cnt_q >= aux_per_q - 32'd1;
   assign aux_thr = (aux_per_q >> 4) * {27'd0, {1'b0, aux_duty_q} + 5'd1};
   assign aux_on = (aux_duty_q == 4'hf) || (aux_cnt_q < aux_thr); // RULE_18

   // period and duty change only at a period end, avoiding runt pulses
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aux_cnt_q <= 32'd0;
         aux_per_q <= 32'd1;
         aux_duty_q <= 4'h0;
      end
      else
      begin
         aux_cnt_q <= aux_end ? 32'd0 : aux_cnt_q + 32'd1;
         if (aux_end)
         begin
            aux_per_q <= aux_div[aux_q[6:4]]; // RULE_12
            aux_duty_q <= aux_q[3:0];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aux_pulse_o <= 1'b0;
         aux_pulse_oe_n <= 1'b1;
      end
      else
      begin
         aux_pulse_o <= 1'b0;
         aux_pulse_oe_n <= !(aux_q[LDF_BIT_EN] && aux_on); // RULE_11
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   logic [8:0] boost_pulses_q;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst) boost_pulses_q <= 9'd0;
      else if (ptick) boost_pulses_q <= frame_end ? 9'd0 : boost_pulses_q + {8'd0, boost_sum[8]};
   end

   boost_frame_count_a: assert property (frame_end |-> // RULE_01 RULE_02
      (boost_pulses_q + {8'd0, boost_sum[8]}) == {1'b0, boost_code_q})
      else $error("boost pulse count per frame differs from code");
   boost_zero_off_a: assert property (ptick && boost_code_q == 8'h00 |=> !white_led_boost) // RULE_01
      else $error("boost output on with zero code");
   duty_latch_a: assert property ($changed(backl_code_q) |-> $past(frame_end)) // RULE_20
      else $error("backlight code changed away from frame boundary");
   blink_off_dark_a: assert property (!blink_en |=> // RULE_17 RULE_03
      !red_sink_on && !green_sink_on && !blue_sink_on)
      else $error("tricolour sink active with blink disabled");
   cont_window_a: assert property (blink_en && cont && red_q[7:6] != 2'b00 && // RULE_05
      r_code_q == 5'd31 |=> red_sink_on)
      else $error("continuous mode left the on window");
   // a shorter period written mid-count wraps at the next tick, so check only after ticks
   period_bound_a: assert property (blink_en && btick |=> bcnt_q < $past(per_ticks)) // RULE_04
      else $error("blink counter passed the period");
   on_time_a: assert property (blink_en && !cont && bcnt_q >= on_ticks |=> // RULE_19 RULE_06
      !red_sink_on && !green_sink_on && !blue_sink_on)
      else $error("tricolour sink on outside on-time");
   no_current_a: assert property (red_q[7:6] == 2'b00 |=> !red_sink_on && !blue_sink_on) // RULE_07
      else $error("sink on with current off");
   aux_disable_a: assert property (!aux_q[LDF_BIT_EN] |=> aux_pulse_oe_n) // RULE_11
      else $error("pulse pin pulled while disabled");
   readback_a: assert property (reg_wr && hit_aux ##1 reg_rd && hit_aux && !reg_wr |=> // RULE_14
      reg_rdata == $past(reg_wdata, 2))
      else $error("register read back differs from write");
   unmapped_rd_a: assert property (reg_rd && !hit_boost && !hit_blink && // RULE_14
      !hit_red && !hit_green && !hit_blue && !hit_aux && !hit_backl |=> reg_rdata == 8'h00)
      else $error("unmapped offset read non-zero");
   cur_off_a: assert property (!blink_en |=> tricolour_sink_current == 2'b00) // RULE_07
      else $error("sink current shown with blink disabled");
   blink_hold_a: assert property (!blink_en |=> bcnt_q == 8'd0) // RULE_03
      else $error("blink counter ran while disabled");
   rgb_full_a: assert property (active && r_code_q == 5'd31 |=> red_sink_on) // RULE_09
      else $error("full red code left a gap");
   slot_range_a: assert property (slot_q < LDF_RGB_SLOTS) // RULE_09
      else $error("colour slot counter out of range");
   boost_hold_a: assert property (!ptick |=> $stable(white_led_boost)) // RULE_16
      else $error("boost output changed inside a pulse");
   frame_wrap_a: assert property (frame_end |=> pidx_q == 8'h00) // RULE_16
      else $error("pulse index did not wrap at frame end");
   aux_full_a: assert property (aux_q[LDF_BIT_EN] && aux_duty_q == 4'hf |=> // RULE_18
      !aux_pulse_oe_n)
      else $error("full pulse duty released the pin");

   blink_run_c: cover property (blink_en && !cont && btick && bcnt_q == on_ticks);
   frame_full_c: cover property (frame_end && boost_code_q == 8'hff);
   aux_pulse_c: cover property (aux_q[LDF_BIT_EN] ##1 !aux_pulse_oe_n ##1 aux_pulse_oe_n);
   rgb_phase_c: cover property (red_sink_on && !green_sink_on && blue_sink_on);
   aux_full_c: cover property (aux_q[LDF_BIT_EN] && aux_duty_q == 4'hf);
endmodule
`default_nettype wire

// File: testbench/ldf_led_dimming_flash_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module ldf_led_dimming_flash_control_test;
   import ldf_pkg::*;
   // small clock figure keeps blink periods inside the run budget
   localparam int unsigned HZ = 64_000;
   localparam int TK = HZ / 20;
   localparam logic [7:0] OFS [7] = '{LDF_OFF_BOOST, LDF_OFF_BLINK, LDF_OFF_RED,
      LDF_OFF_GREEN, LDF_OFF_BLUE, LDF_OFF_AUX, LDF_OFF_BACKLIGHT};
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic frame_rate_select = 1'b1;
   logic [7:0] reg_rdata;
   logic boost, bl, red, grn, blu, ao, aoe_n;
   logic [1:0] cur;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int cnt [8];
   int pc;
   ////////////////////////////////////////////////////////////////////////////
   ldf_led_dimming_flash_control #(.CLK_HZ(HZ)) u_ldf_led_dimming_flash_control (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .frame_rate_select(frame_rate_select),
      .white_led_boost(boost),
      .backlight_dimming_output(bl),
      .red_sink_on(red),
      .green_sink_on(grn),
      .blue_sink_on(blu),
      .tricolour_sink_current(cur),
      .aux_pulse_o(ao),
      .aux_pulse_oe_n(aoe_n)
   );
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 95000)
      begin
         fails = fails + 1;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("compares %0d unexpected %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   // two edges: read data holds until the next read strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      @(negedge sys_clk);
      chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
   endtask
   // write then read on the very next edge
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk("reg_rdata_b2b", {24'h0, d}, {24'h0, reg_rdata});
   endtask
   // counts are periodic, so any window of whole frames is exact
   task automatic win(input int n);
      cnt = '{default: 0};
      repeat (n)
      begin
         @(negedge sys_clk);
         cnt[0] += (boost === 1'b1);
         cnt[1] += (bl === 1'b1);
         cnt[2] += (red === 1'b1);
         cnt[3] += (grn === 1'b1);
         cnt[4] += (blu === 1'b1);
         cnt[5] += (red === 1'b1 && grn === 1'b1);
         cnt[6] += (red === 1'b1 && blu === 1'b1);
         cnt[7] += (aoe_n === 1'b0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] p;
      foreach (OFS[i])
         rd_chk(OFS[i], 8'h00);
      rd_chk(8'h20, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         p = k ? 8'h5a : 8'ha5;
         foreach (OFS[i])
            wr(OFS[i], p ^ 8'(i));
         wr(8'h20, 8'hff);
         foreach (OFS[i])
            rd_chk(OFS[i], p ^ 8'(i));
         rd_chk(8'h20, 8'h00);
      end
      wr_rd(LDF_OFF_AUX, 8'h3c);
      foreach (OFS[i])
         wr(OFS[i], 8'h00);
   endtask
   task automatic t_dim(input logic fr, input logic [7:0] code);
      frame_rate_select = fr;
      pc = HZ / ((fr ? LDF_FRAME_HZ_HI : LDF_FRAME_HZ_LO) * 256);
      wr(LDF_OFF_BOOST, code);
      wr(LDF_OFF_BACKLIGHT, code);
      repeat (3 * 256 * pc) @(negedge sys_clk);
      win(256 * pc);
      chk("boost_high", code * pc, cnt[0]);
      chk("backlight_high", code * pc, cnt[1]);
   endtask
   task automatic t_cur(input logic en);
      for (int c = 0; c < 4; c++)
      begin
         wr(LDF_OFF_BLINK, {en, 7'h0f});
         wr(LDF_OFF_RED, {2'(c), 6'h1f});
         repeat (100) @(negedge sys_clk);
         win(31 * pc);
         chk("sink_current", en ? c : 0, cur);
         chk("red_high", (en && c > 0) ? 31 * pc : 0, cnt[2]);
      end
   endtask
   task automatic t_rgb(input logic ph);
      wr(LDF_OFF_BLINK, 8'h8f);
      wr(LDF_OFF_RED, {2'b10, ph, 5'd15});
      wr(LDF_OFF_GREEN, 8'hef);
      wr(LDF_OFF_BLUE, 8'h0f);
      repeat (100) @(negedge sys_clk);
      win(62 * pc);
      chk("red_high", 30 * pc, cnt[2]);
      chk("green_high", 30 * pc, cnt[3]);
      chk("blue_high", 30 * pc, cnt[4]);
      chk("red_green", ph ? 30 * pc : 0, cnt[5]);
      chk("red_blue", ph ? 0 : 30 * pc, cnt[6]);
   endtask
   task automatic t_blink();
      int n = 0;
      wr(LDF_OFF_BLINK, 8'h00);
      wr(LDF_OFF_RED, 8'h5f);
      // colour code only latches at the slot frame end
      repeat (40) @(negedge sys_clk);
      wr(LDF_OFF_BLINK, 8'hf0);
      while (red !== 1'b1 && n < 100)
      begin
         @(negedge sys_clk);
         n++;
      end
      n = 0;
      while (red === 1'b1 && n < 70000)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk("on_time", 12 * TK, n);
      while (red !== 1'b1 && n < 70000)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk("blink_period", 20 * TK, n);
      chk("sink_current", 1, cur);
   endtask
   task automatic t_aux(input logic [2:0] f, input logic [3:0] d);
      int p;
      p = HZ / LDF_AUX_HZ[f];
      wr(LDF_OFF_AUX, {1'b1, f, d});
      repeat (300) @(negedge sys_clk);
      win(4 * p);
      chk("aux_pulled", (d == 15) ? 4 * p : 4 * (p / 16) * (d + 1), cnt[7]);
      chk("aux_pin", 0, ao);
   endtask
   task automatic t_aux_off();
      wr(LDF_OFF_AUX, 8'h7f);
      repeat (300) @(negedge sys_clk);
      win(256);
      chk("aux_disabled", 0, cnt[7]);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk("oe_n_reset", 1, aoe_n);
      t_regs();
      t_dim(1'b1, 8'h00);
      t_dim(1'b1, 8'h01);
      t_dim(1'b1, 8'h80);
      t_dim(1'b1, 8'hff);
      t_dim(1'b0, 8'h80);
      t_dim(1'b1, 8'h00);
      t_cur(1'b0);
      t_cur(1'b1);
      t_rgb(1'b0);
      t_rgb(1'b1);
      t_blink();
      // odd duty codes per frequency, top code on the slowest
      for (int f = 0; f < 8; f++)
         t_aux(3'(f), 4'(2 * f + 1));
      t_aux(3'd7, 4'd0);
      t_aux_off();
      stop_test();
   end
endmodule
`default_nettype wire
